/* verilog/dpcm_pixel_decompressor_10bit.sv */
// Top of the 10-bit pixel decompressor.
`timescale 1ns/1ps
`include "dpcm_cfg.svh"
module dpcm_pixel_decompressor_10bit #(
   parameter int LINE_CNT_W = 16
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // Compressed sample stream
   input  wire logic                  in_valid,
   input  dpcm_pkg::sample_t          in_sample,
   // Line control
   input  wire logic                  line_start,
   input  wire logic                  line_end,
   input  wire logic [1:0]            mode_sel,
   // Decoded pixel stream
   output logic                       out_valid,
   output dpcm_pkg::pixel_t           out_pixel,
   // Status
   output logic                       line_active,
   output logic                       mode_error,
   output logic [LINE_CNT_W-1:0]      sample_count
);

   // -----------------------------------------------------------------------------
   // Internal signals
   // -----------------------------------------------------------------------------
   dpcm_pkg::line_state_t state;
   dpcm_pkg::mode_t       mode;
   dpcm_pkg::mode_t       next_mode;
   dpcm_pkg::decode_t     dec;
   dpcm_pkg::pixel_t      next_pixel;
   logic                  sel_legal;
   logic                  sel_differs;
   logic [7:0]            code_m;
   logic [9:0]            raw_value;
   logic [9:0]            diff_value;
   logic                  diff_sat;

   // -----------------------------------------------------------------------------
   // Helper functions
   // -----------------------------------------------------------------------------

   // Maps a selection code onto a scheme; illegal codes fall back to 10-8-10.
   function automatic dpcm_pkg::mode_t sel_to_mode(input logic [1:0] sel);
      case (sel)
         `MODE_SEL_7: return dpcm_pkg::MODE_10_7_10;
         `MODE_SEL_6: return dpcm_pkg::MODE_10_6_10;
         default:     return dpcm_pkg::MODE_10_8_10;
      endcase
   endfunction

   // Returns the selection code that stands for a scheme.
   function automatic logic [1:0] mode_to_sel(input dpcm_pkg::mode_t m);
      case (m)
         dpcm_pkg::MODE_10_7_10: return `MODE_SEL_7;
         dpcm_pkg::MODE_10_6_10: return `MODE_SEL_6;
         default:                return `MODE_SEL_8;
      endcase
   endfunction

   // -----------------------------------------------------------------------------
   // Scheme selection checks
   // -----------------------------------------------------------------------------

   // A selection is legal only for the three defined codes.
   always_comb begin
      sel_legal   = (mode_sel == `MODE_SEL_8) || (mode_sel == `MODE_SEL_7) || (mode_sel == `MODE_SEL_6);
      sel_differs = mode_sel != mode_to_sel(mode);
      next_mode   = sel_legal ? sel_to_mode(mode_sel) : mode;
   end

   // -----------------------------------------------------------------------------
   // Line state machine
   // -----------------------------------------------------------------------------

   // Tracks whether a line is open; a new start always reopens a line.
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= dpcm_pkg::LINE_IDLE;
      end else begin
         case (state)
            dpcm_pkg::LINE_IDLE: begin
               if (line_start) begin
                  state <= dpcm_pkg::LINE_ACTIVE;
               end
            end
            dpcm_pkg::LINE_ACTIVE: begin
               if (line_end && !line_start) begin
                  state <= dpcm_pkg::LINE_IDLE;
               end
            end
            default: begin
               state <= dpcm_pkg::LINE_IDLE;
            end
         endcase
      end
   end

   // Mirrors the line state on a dedicated output flop.
   always_ff @(posedge clk) begin
      if (reset) begin
         line_active <= 1'b0;
      end else if (line_start) begin
         line_active <= 1'b1;
      end else if (line_end) begin
         line_active <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------------
   // Scheme latch and selection error
   // -----------------------------------------------------------------------------

   // [R22] scheme held per line.
   always_ff @(posedge clk) begin
      if (reset) begin
         mode <= dpcm_pkg::MODE_10_8_10;
      end else if (line_start) begin
         mode <= next_mode;
      end
   end

   // Sticky error for a bad or shifting selection; a line start decides afresh.
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_error <= 1'b0;
      end else if (line_start) begin
         mode_error <= !sel_legal;
      end else if (state == dpcm_pkg::LINE_ACTIVE && sel_differs) begin
         mode_error <= 1'b1;
      end
   end

   // -----------------------------------------------------------------------------
   // Samples per line
   // -----------------------------------------------------------------------------

   // Samples since the last line start, one taken with it included.
   always_ff @(posedge clk) begin
      if (reset) begin
         sample_count <= '0;
      end else if (line_start) begin
         sample_count <= in_valid ? LINE_CNT_W'(1) : '0;
      end else if (in_valid) begin
         sample_count <= sample_count + LINE_CNT_W'(1);
      end
   end

   // -----------------------------------------------------------------------------
   // Code reconstruction
   // -----------------------------------------------------------------------------

   // Keeps only the code bits that the current scheme transmits.
   always_comb begin
      case (mode)
         dpcm_pkg::MODE_10_7_10: code_m = in_sample.code & `CODE_MASK_7;
         dpcm_pkg::MODE_10_6_10: code_m = in_sample.code & `CODE_MASK_6;
         default:                code_m = in_sample.code & `CODE_MASK_8;
      endcase
   end

   // [R2] unpredicted mid-step reconstruction.
   always_comb begin
      case (mode)
         dpcm_pkg::MODE_10_7_10: raw_value = dpcm_pkg::scaled(code_m, `CODE_MASK_7, `RAW_SH_7, `RAW_OFS_7);
         dpcm_pkg::MODE_10_6_10: raw_value = dpcm_pkg::scaled(code_m, `CODE_MASK_6, `RAW_SH_6, `RAW_OFS_6);
         default:                raw_value = dpcm_pkg::scaled(code_m, `CODE_MASK_8, `RAW_SH_8, `RAW_OFS_8);
      endcase
   end

   // Class decoding of predicted codes.
   dpcm_class_decode u_class_decode (
      .mode (mode),
      .code (code_m),
      .dec  (dec)
   );

   // Difference and absolute application against the prediction.
   dpcm_diff_apply u_diff_apply (
      .pred      (in_sample.pred),
      .dec       (dec),
      .value     (diff_value),
      .saturated (diff_sat)
   );

   // [R1] formula chosen by prediction flag.
   always_comb begin
      if (in_sample.no_pred) begin
         next_pixel.value     = raw_value;
         next_pixel.cls       = dpcm_pkg::CLS_RAW;
         next_pixel.saturated = 1'b0;
      end else begin
         next_pixel.value     = diff_value;
         next_pixel.cls       = dec.cls;
         next_pixel.saturated = diff_sat;
      end
   end

   // -----------------------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------------------

   // [R21] one result per sample.
   always_ff @(posedge clk) begin
      if (reset) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid;
      end
   end

   // Pixel holds its last value between samples.
   always_ff @(posedge clk) begin
      if (reset) begin
         out_pixel <= '0;
      end else if (in_valid) begin
         out_pixel <= next_pixel;
      end
   end

endmodule

/* verilog/dpcm_cfg.svh */
// Constants of the 10-bit pixel decompressor.
// Functional notes
// [R1] Unpredicted samples bypass class decoding.
// [R2] Unpredicted output: code x4+2, x8+4 or x16+8.
// [R3] 10-8-10 order: DPCM1, DPCM2, DPCM3, else PCM.
// [R4] 10-8-10 DPCM1: sign 0x20, low five bits, unclamped.
// [R5] 10-8-10 DPCM2: sign 0x10, 2x low four bits +32, unclamped.
// [R6] 10-8-10 DPCM3: 4x low four bits +65, saturated.
// [R7] 10-8-10 PCM: 8x low seven bits, +3 above prediction, else +4.
// [R8] 10-7-10 order: DPCM1 to DPCM4, else PCM.
// [R9] 10-7-10 DPCM1: sign 0x8, low three bits, unclamped.
// [R10] 10-7-10 DPCM2: sign 0x4, 2x low two bits +8, unclamped.
// [R11] 10-7-10 DPCM3: 4x low two bits +17, saturated.
// [R12] 10-7-10 DPCM4: sign 0x10, 8x low four bits +35, saturated.
// [R13] 10-7-10 PCM: 16x low six bits, +7 above prediction, else +8.
// [R14] 10-6-10 order: DPCM1 to DPCM5, else PCM.
// [R15] 10-6-10 DPCM1: prediction unchanged.
// [R16] 10-6-10 DPCM2: prediction minus one if signed, else plus one.
// [R17] 10-6-10 DPCM3: sign 0x2, 4x lowest bit +4, saturated.
// [R18] 10-6-10 DPCM4: sign 0x4, 8x low two bits +14, saturated.
// [R19] 10-6-10 DPCM5: sign 0x8, 16x low three bits +50, saturated.
// [R20] 10-6-10 PCM: 32x low five bits, +15 above prediction, else +16.
// [R21] Prediction and flag come with each code; one result per valid sample.
// [R22] Controller fixes one scheme before a line and holds it.
`ifndef DPCM_CFG_SVH
`define DPCM_CFG_SVH

// -----------------------------------------------------------------------------
// General widths, limits and mode selection codes
// -----------------------------------------------------------------------------
`define PIX_MAX       10'h3FF
`define NO_SHIFT      3'h0
`define NO_OFS        10'h000
`define MODE_SEL_8    2'h0
`define MODE_SEL_7    2'h1
`define MODE_SEL_6    2'h2
`define CODE_MASK_8   8'hFF
`define CODE_MASK_7   8'h7F
`define CODE_MASK_6   8'h3F

// -----------------------------------------------------------------------------
// Unpredicted sample reconstruction
// -----------------------------------------------------------------------------
`define RAW_SH_8      3'h2
`define RAW_OFS_8     10'h002
`define RAW_SH_7      3'h3
`define RAW_OFS_7     10'h004
`define RAW_SH_6      3'h4
`define RAW_OFS_6     10'h008

// -----------------------------------------------------------------------------
// 10-8-10 scheme
// -----------------------------------------------------------------------------
`define M8_D1_MASK    8'hC0
`define M8_D1_VAL     8'h00
`define M8_D23_MASK   8'hE0
`define M8_D2_VAL     8'h40
`define M8_D3_VAL     8'h60
`define M8_D1_SIGN    8'h20
`define M8_D1_FIELD   8'h1F
`define M8_D23_SIGN   8'h10
`define M8_D23_FIELD  8'h0F
`define M8_D2_SH      3'h1
`define M8_D2_OFS     10'h020
`define M8_D3_SH      3'h2
`define M8_D3_OFS     10'h041
`define M8_PCM_FIELD  8'h7F
`define M8_PCM_SH     3'h3
`define M8_PCM_LO     10'h003
`define M8_PCM_HI     10'h004

// -----------------------------------------------------------------------------
// 10-7-10 scheme
// -----------------------------------------------------------------------------
`define M7_D1_MASK    8'h70
`define M7_D1_VAL     8'h00
`define M7_D23_MASK   8'h78
`define M7_D2_VAL     8'h10
`define M7_D3_VAL     8'h18
`define M7_D4_MASK    8'h60
`define M7_D4_VAL     8'h20
`define M7_D1_SIGN    8'h08
`define M7_D1_FIELD   8'h07
`define M7_D23_SIGN   8'h04
`define M7_D23_FIELD  8'h03
`define M7_D2_SH      3'h1
`define M7_D2_OFS     10'h008
`define M7_D3_SH      3'h2
`define M7_D3_OFS     10'h011
`define M7_D4_SIGN    8'h10
`define M7_D4_FIELD   8'h0F
`define M7_D4_SH      3'h3
`define M7_D4_OFS     10'h023
`define M7_PCM_FIELD  8'h3F
`define M7_PCM_SH     3'h4
`define M7_PCM_LO     10'h007
`define M7_PCM_HI     10'h008

// -----------------------------------------------------------------------------
// 10-6-10 scheme
// -----------------------------------------------------------------------------
`define M6_D12_MASK   8'h3E
`define M6_D1_VAL     8'h00
`define M6_D2_VAL     8'h02
`define M6_D3_MASK    8'h3C
`define M6_D3_VAL     8'h04
`define M6_D4_MASK    8'h38
`define M6_D4_VAL     8'h08
`define M6_D5_MASK    8'h30
`define M6_D5_VAL     8'h10
`define M6_D2_SIGN    8'h01
`define M6_D2_OFS     10'h001
`define M6_D3_SIGN    8'h02
`define M6_D3_FIELD   8'h01
`define M6_D3_SH      3'h2
`define M6_D3_OFS     10'h004
`define M6_D4_SIGN    8'h04
`define M6_D4_FIELD   8'h03
`define M6_D4_SH      3'h3
`define M6_D4_OFS     10'h00E
`define M6_D5_SIGN    8'h08
`define M6_D5_FIELD   8'h07
`define M6_D5_SH      3'h4
`define M6_D5_OFS     10'h032
`define M6_PCM_FIELD  8'h1F
`define M6_PCM_SH     3'h5
`define M6_PCM_LO     10'h00F
`define M6_PCM_HI     10'h010

`endif

/* verilog/dpcm_pkg.sv */
// Types and shared arithmetic of the 10-bit pixel decompressor.
package dpcm_pkg;

   // -----------------------------------------------------------------------------
   // Enumerations
   // -----------------------------------------------------------------------------
   typedef enum logic [1:0] {MODE_10_8_10, MODE_10_7_10, MODE_10_6_10} mode_t;
   typedef enum logic [2:0] {CLS_DPCM1, CLS_DPCM2, CLS_DPCM3, CLS_DPCM4, CLS_DPCM5, CLS_PCM, CLS_RAW} class_t;
   typedef enum logic {LINE_IDLE, LINE_ACTIVE} line_state_t;

   // -----------------------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] code;
      logic [9:0] pred;
      logic       no_pred;
   } sample_t;

   typedef struct packed {
      logic [9:0] value;
      class_t     cls;
      logic       saturated;
   } pixel_t;

   typedef struct packed {
      class_t     cls;
      logic       sign;
      logic [9:0] mag;
      logic       sat_en;
      logic [9:0] pcm_base;
      logic [9:0] pcm_lo;
      logic [9:0] pcm_hi;
   } decode_t;

   // Masks a field, shifts it up and adds an offset, all at pixel width.
   function automatic logic [9:0] scaled(input logic [7:0] code, input logic [7:0] field,
                                         input logic [2:0] sh, input logic [9:0] ofs);
      logic [9:0] wide;
      wide = {2'h0, code & field} << sh;
      return wide + ofs;
   endfunction

endpackage

/* verilog/dpcm_class_decode.sv */
// Class selection and field extraction of a predicted compressed code.
`timescale 1ns/1ps
`include "dpcm_cfg.svh"
module dpcm_class_decode (
   // Selected scheme and masked code
   input  dpcm_pkg::mode_t   mode,
   input  wire logic [7:0]   code,
   // Decoded class and fields
   output dpcm_pkg::decode_t dec
);

   // True when the masked code bits equal the class prefix.
   function automatic logic hit(input logic [7:0] c, input logic [7:0] mask, input logic [7:0] val);
      return (c & mask) == val;
   endfunction

   // Class priority chains for the three schemes; PCM is the fall-through.
   always_comb begin
      dec        = '0;
      dec.cls    = dpcm_pkg::CLS_PCM;
      dec.pcm_lo = `M8_PCM_LO;
      dec.pcm_hi = `M8_PCM_HI;
      case (mode)
         // [R3] 10-8-10 chain.
         dpcm_pkg::MODE_10_8_10: begin
            dec.pcm_base = dpcm_pkg::scaled(code, `M8_PCM_FIELD, `M8_PCM_SH, `NO_OFS);
            if (hit(code, `M8_D1_MASK, `M8_D1_VAL)) begin
               // [R4] small difference.
               dec.cls  = dpcm_pkg::CLS_DPCM1;
               dec.sign = |(code & `M8_D1_SIGN);
               dec.mag  = dpcm_pkg::scaled(code, `M8_D1_FIELD, `NO_SHIFT, `NO_OFS);
            end else if (hit(code, `M8_D23_MASK, `M8_D2_VAL)) begin
               // [R5] medium difference.
               dec.cls  = dpcm_pkg::CLS_DPCM2;
               dec.sign = |(code & `M8_D23_SIGN);
               dec.mag  = dpcm_pkg::scaled(code, `M8_D23_FIELD, `M8_D2_SH, `M8_D2_OFS);
            end else if (hit(code, `M8_D23_MASK, `M8_D3_VAL)) begin
               // [R6] large difference, saturated.
               dec.cls    = dpcm_pkg::CLS_DPCM3;
               dec.sign   = |(code & `M8_D23_SIGN);
               dec.mag    = dpcm_pkg::scaled(code, `M8_D23_FIELD, `M8_D3_SH, `M8_D3_OFS);
               dec.sat_en = 1'b1;
            end
         end
         // [R8] 10-7-10 chain.
         dpcm_pkg::MODE_10_7_10: begin
            dec.pcm_base = dpcm_pkg::scaled(code, `M7_PCM_FIELD, `M7_PCM_SH, `NO_OFS);
            dec.pcm_lo   = `M7_PCM_LO;
            dec.pcm_hi   = `M7_PCM_HI;
            if (hit(code, `M7_D1_MASK, `M7_D1_VAL)) begin
               // [R9] small difference.
               dec.cls  = dpcm_pkg::CLS_DPCM1;
               dec.sign = |(code & `M7_D1_SIGN);
               dec.mag  = dpcm_pkg::scaled(code, `M7_D1_FIELD, `NO_SHIFT, `NO_OFS);
            end else if (hit(code, `M7_D23_MASK, `M7_D2_VAL)) begin
               // [R10] medium difference.
               dec.cls  = dpcm_pkg::CLS_DPCM2;
               dec.sign = |(code & `M7_D23_SIGN);
               dec.mag  = dpcm_pkg::scaled(code, `M7_D23_FIELD, `M7_D2_SH, `M7_D2_OFS);
            end else if (hit(code, `M7_D23_MASK, `M7_D3_VAL)) begin
               // [R11] saturated difference.
               dec.cls    = dpcm_pkg::CLS_DPCM3;
               dec.sign   = |(code & `M7_D23_SIGN);
               dec.mag    = dpcm_pkg::scaled(code, `M7_D23_FIELD, `M7_D3_SH, `M7_D3_OFS);
               dec.sat_en = 1'b1;
            end else if (hit(code, `M7_D4_MASK, `M7_D4_VAL)) begin
               // [R12] largest difference, saturated.
               dec.cls    = dpcm_pkg::CLS_DPCM4;
               dec.sign   = |(code & `M7_D4_SIGN);
               dec.mag    = dpcm_pkg::scaled(code, `M7_D4_FIELD, `M7_D4_SH, `M7_D4_OFS);
               dec.sat_en = 1'b1;
            end
         end
         // [R14] 10-6-10 chain.
         dpcm_pkg::MODE_10_6_10: begin
            dec.pcm_base = dpcm_pkg::scaled(code, `M6_PCM_FIELD, `M6_PCM_SH, `NO_OFS);
            dec.pcm_lo   = `M6_PCM_LO;
            dec.pcm_hi   = `M6_PCM_HI;
            if (hit(code, `M6_D12_MASK, `M6_D1_VAL)) begin
               // [R15] zero difference, sign ignored.
               dec.cls = dpcm_pkg::CLS_DPCM1;
            end else if (hit(code, `M6_D12_MASK, `M6_D2_VAL)) begin
               // [R16] unit step.
               dec.cls  = dpcm_pkg::CLS_DPCM2;
               dec.sign = |(code & `M6_D2_SIGN);
               dec.mag  = `M6_D2_OFS;
            end else if (hit(code, `M6_D3_MASK, `M6_D3_VAL)) begin
               // [R17] saturated difference.
               dec.cls    = dpcm_pkg::CLS_DPCM3;
               dec.sign   = |(code & `M6_D3_SIGN);
               dec.mag    = dpcm_pkg::scaled(code, `M6_D3_FIELD, `M6_D3_SH, `M6_D3_OFS);
               dec.sat_en = 1'b1;
            end else if (hit(code, `M6_D4_MASK, `M6_D4_VAL)) begin
               // [R18] saturated difference.
               dec.cls    = dpcm_pkg::CLS_DPCM4;
               dec.sign   = |(code & `M6_D4_SIGN);
               dec.mag    = dpcm_pkg::scaled(code, `M6_D4_FIELD, `M6_D4_SH, `M6_D4_OFS);
               dec.sat_en = 1'b1;
            end else if (hit(code, `M6_D5_MASK, `M6_D5_VAL)) begin
               // [R19] largest difference, saturated.
               dec.cls    = dpcm_pkg::CLS_DPCM5;
               dec.sign   = |(code & `M6_D5_SIGN);
               dec.mag    = dpcm_pkg::scaled(code, `M6_D5_FIELD, `M6_D5_SH, `M6_D5_OFS);
               dec.sat_en = 1'b1;
            end
         end
         default: dec.cls = dpcm_pkg::CLS_PCM;
      endcase
   end

endmodule

/* verilog/dpcm_diff_apply.sv */
// Applies a decoded difference or absolute code to the prediction.
`timescale 1ns/1ps
`include "dpcm_cfg.svh"
module dpcm_diff_apply (
   // Prediction and decoded fields
   input  wire logic [9:0]   pred,
   input  dpcm_pkg::decode_t dec,
   // Reconstructed value
   output logic [9:0]        value,
   output logic              saturated
);

   logic [11:0] plus;
   logic [11:0] minus;
   logic        under;
   logic        over;

   // Twelve-bit sums keep borrow and carry visible for clamping.
   always_comb begin
      plus  = {2'h0, pred} + {2'h0, dec.mag};
      minus = {2'h0, pred} - {2'h0, dec.mag};
      under = dec.mag > pred;
      over  = plus > {2'h0, `PIX_MAX};
   end

   // Result selection; unclamped classes keep the low ten bits.
   always_comb begin
      value     = pred;
      saturated = 1'b0;
      if (dec.cls == dpcm_pkg::CLS_PCM) begin
         // [R7] [R13] [R20] absolute code rounding.
         value = (dec.pcm_base > pred) ? dec.pcm_base + dec.pcm_lo : dec.pcm_base + dec.pcm_hi;
      end else if (dec.sign) begin
         // [R6] [R11] [R12] [R17] [R18] [R19] clamp at zero.
         value     = (dec.sat_en && under) ? '0 : minus[9:0];
         saturated = dec.sat_en && under;
      end else begin
         // [R6] [R11] [R12] [R17] [R18] [R19] clamp at full scale.
         value     = (dec.sat_en && over) ? `PIX_MAX : plus[9:0];
         saturated = dec.sat_en && over;
      end
   end

endmodule

/* test/dpcm_decomp_monitor.sv */
// Port checker of the pixel decompressor.
`timescale 1ns/1ps
module dpcm_decomp_monitor (
   // Clock, reset and inputs
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   input  dpcm_pkg::sample_t     in_sample,
   input  wire logic             line_start,
   input  wire logic [1:0]       mode_sel,
   // Outputs
   input  wire logic             out_valid,
   input  dpcm_pkg::pixel_t      out_pixel,
   input  wire logic             line_active,
   input  wire logic             mode_error
);
   logic [1:0] cur;
   wire logic [7:0] cv = in_sample.code;
   wire logic [9:0] pv = in_sample.pred;
   wire logic [9:0] d1 = cv[5] ? pv - {5'h00, cv[4:0]} : pv + {5'h00, cv[4:0]};
   wire logic [9:0] pb = {cv[6:0], 3'h0};
   wire logic [9:0] pcm = pb + ((pb > pv) ? 10'h003 : 10'h004);
   wire logic [9:0] raw = (cur == 2'h0) ? {cv, 2'h2} : (cur == 2'h1) ? {cv[6:0], 3'h4} : {cv[5:0], 4'h8};
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Follows the scheme latched by a legal line start.
   always_ff @(posedge clk) begin
      if (reset) cur <= 2'h0;
      else if (line_start && mode_sel != 2'h3) cur <= mode_sel;
   end
   sequence s_take;
      in_valid && !in_sample.no_pred;
   endsequence
   chk_valid_echo: assert property (in_valid |=> out_valid)
      else $error("sample gave no output pulse");
   chk_no_spurious: assert property (!in_valid |=> !out_valid)
      else $error("output pulse without sample");
   chk_raw_value: assert property (in_valid && in_sample.no_pred |=> out_pixel.value == $past(raw)
      && out_pixel.cls == dpcm_pkg::CLS_RAW) else $error("unpredicted value wrong");
   chk_small_diff: assert property (s_take ##0 cur == 2'h0 && cv[7:6] == 2'h0 |=> out_pixel.value == $past(d1))
      else $error("small difference value wrong");
   chk_pcm_eight: assert property (s_take ##0 cur == 2'h0 && cv[7] |=> out_pixel.value == $past(pcm))
      else $error("absolute code value wrong");
   chk_zero_diff: assert property (s_take ##0 cur == 2'h2 && cv[5:1] == 5'h00 |=> out_pixel.value == $past(pv))
      else $error("zero difference changed value");
   chk_sat_rail: assert property (out_valid && out_pixel.saturated |-> out_pixel.value inside {10'h000, 10'h3FF})
      else $error("saturated value off the rails");
   chk_line_open: assert property (line_start && mode_sel != 2'h3 |=> line_active && !mode_error)
      else $error("legal line start not taken");
   chk_bad_mode: assert property (line_start && mode_sel == 2'h3 |=> mode_error [*2] or line_start)
      else $error("illegal scheme not flagged");
endmodule
bind dpcm_pixel_decompressor_10bit dpcm_decomp_monitor mon (.clk(clk), .reset(reset), .in_valid(in_valid),
   .in_sample(in_sample), .line_start(line_start), .mode_sel(mode_sel), .out_valid(out_valid),
   .out_pixel(out_pixel), .line_active(line_active), .mode_error(mode_error));

/* test/pixel_sink.sv */
// Downstream pipeline stand-in that counts delivered pixels.
`timescale 1ns/1ps
module pixel_sink (
   // Clock, reset and pixel pulse
   input  wire logic  clk,
   input  wire logic  reset,
   input  wire logic  out_valid,
   // Pixels taken
   output logic [15:0] got
);
   always_ff @(posedge clk) begin
      if (reset) got <= 16'h0000;
      else if (out_valid) got <= got + 16'h0001;
   end
endmodule

/* test/tb_top.sv */
// Self-checking bench of the pixel decompressor.
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic [1:0] m; logic [7:0] c; logic [9:0] p; logic n; logic [9:0] e;} row_t;
   logic clk, reset, in_valid, line_start, line_end, out_valid, line_active, mode_error;
   logic [1:0] mode_sel;
   logic [15:0] sample_count, got;
   dpcm_pkg::sample_t in_sample;
   dpcm_pkg::pixel_t out_pixel;
   int n_fail, compares, cyc;
   wire logic [17:0] snap = {out_valid, line_active, mode_error, sample_count[4:0], out_pixel.value};
   row_t rows [23] = '{
      {2'h0,8'h10,10'h000,1'h1,10'h042}, {2'h0,8'h05,10'h100,1'h0,10'h105}, {2'h0,8'h25,10'h003,1'h0,10'h3FE},
      {2'h0,8'h43,10'h100,1'h0,10'h126}, {2'h0,8'h53,10'h100,1'h0,10'h0DA}, {2'h0,8'h6F,10'h3F0,1'h0,10'h3FF},
      {2'h0,8'h7F,10'h010,1'h0,10'h000}, {2'h0,8'h81,10'h000,1'h0,10'h00B}, {2'h0,8'h81,10'h008,1'h0,10'h00C},
      {2'h1,8'h10,10'h000,1'h1,10'h084}, {2'h1,8'h0D,10'h100,1'h0,10'h0FB}, {2'h1,8'h13,10'h100,1'h0,10'h10E},
      {2'h1,8'h1F,10'h00A,1'h0,10'h000}, {2'h1,8'h2F,10'h3A0,1'h0,10'h3FF}, {2'h1,8'h41,10'h020,1'h0,10'h018},
      {2'h1,8'hC1,10'h000,1'h0,10'h017}, {2'h2,8'h3F,10'h000,1'h1,10'h3F8}, {2'h2,8'h01,10'h155,1'h0,10'h155},
      {2'h2,8'h03,10'h155,1'h0,10'h154}, {2'h2,8'h05,10'h100,1'h0,10'h108}, {2'h2,8'h0F,10'h010,1'h0,10'h000},
      {2'h2,8'h17,10'h300,1'h0,10'h3A2}, {2'h2,8'h3F,10'h000,1'h0,10'h3EF}};
   dpcm_pixel_decompressor_10bit DUT (.clk(clk), .reset(reset), .in_valid(in_valid), .in_sample(in_sample),
      .line_start(line_start), .line_end(line_end), .mode_sel(mode_sel), .out_valid(out_valid),
      .out_pixel(out_pixel), .line_active(line_active), .mode_error(mode_error), .sample_count(sample_count));
   pixel_sink sink (.clk(clk), .reset(reset), .out_valid(out_valid), .got(got));
   // Clock of 50 ns.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [17:0] want, input logic [17:0] mask);
      compares++;
      if ((snap & mask) !== (want & mask)) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, snap & mask, want & mask);
      end
   endtask
   task automatic chk_got(input logic [15:0] want);
      compares++;
      if (got !== want) begin
         n_fail++;
         $display("wrong value at %0t: %0d pixels, expected %0d", $time, got, want);
      end
   endtask
   task automatic conclude;
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Opens a line in the row's scheme and sends its one sample.
   task automatic send(input row_t r);
      @(posedge clk) {line_start, mode_sel} <= {1'b1, r.m};
      @(posedge clk) {line_start, in_valid, in_sample} <= {2'b01, r.c, r.p, r.n};
      @(posedge clk) in_valid <= 1'b0;
      @(negedge clk);
   endtask
   // Cuts a hung run short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 600) begin
         n_fail++;
         conclude();
      end
   end
   // Main sequence.
   initial begin
      {reset, in_valid, line_start, line_end, mode_sel, in_sample} = {4'h8, 2'h0, 19'h00000};
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk) chk(18'h00000, 18'h3FFFF);
      $display("test reset done");
      foreach (rows[i]) begin
         send(rows[i]);
         chk({3'b110, 5'h01, rows[i].e}, 18'h3FFFF);
      end
      $display("test table done");
      @(posedge clk) {line_start, mode_sel} <= 3'b101;
      @(posedge clk) {line_start, in_valid, in_sample} <= {2'b01, 8'h05, 10'h100, 1'h0};
      @(posedge clk) in_sample <= {8'h0D, 10'h100, 1'h0};
      @(negedge clk) chk({3'b110, 5'h01, 10'h105}, 18'h3FFFF);
      @(posedge clk) in_valid <= 1'b0;
      @(negedge clk) chk({3'b110, 5'h02, 10'h0FB}, 18'h3FFFF);
      $display("test back to back done");
      send('{2'h3, 8'h10, 10'h000, 1'h1, 10'h084});
      chk({3'b111, 5'h01, 10'h084}, 18'h3FFFF);
      @(posedge clk) line_end <= 1'b1;
      @(posedge clk) line_end <= 1'b0;
      @(negedge clk) chk({3'b001, 15'h0000}, 18'h38000);
      @(posedge clk) {line_start, mode_sel} <= 3'b110;
      @(posedge clk) line_start <= 1'b0;
      @(negedge clk) chk({3'b010, 5'h00, 10'h000}, 18'h3FC00);
      chk_got(16'h001A);
      $display("test line control done");
      conclude();
   end
endmodule
